//--- src/pin_sync.sv
`timescale 1ns/1ps
`include "up_down_counter_consts.svh"

module pin_sync (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [`SYNC_W-1:0]   pin_in,
    output logic      [`SYNC_W-1:0]   pin_out
);

    logic [`SYNC_W-1:0] stage1;
    logic [`SYNC_W-1:0] stage2;
    logic [`SYNC_W-1:0] next_stage1;
    logic [`SYNC_W-1:0] next_stage2;

    // First stage feeds only the second stage
    always_comb begin
        next_stage1 = pin_in;
        next_stage2 = stage1;
        if (!aresetn) begin
            next_stage1 = `SYNC_RESET;
            next_stage2 = `SYNC_RESET;
        end
    end

    always_ff @(posedge aclk) begin
        stage1 <= next_stage1;
        stage2 <= next_stage2;
    end

    assign pin_out = stage2;

endmodule

//--- src/up_down_counter_8bit.sv
// The implementer's own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "up_down_counter_consts.svh"

// Notes on behaviour
// - All eight count bits are one register updated together on the rising clock edge.
// - The selects, read high then low, give clear, count down, load and count up.
// - With both selects low the count output is forced to zero at once, not at an edge.
// - In load mode counting stops and the parallel data is taken at the next rising edge.
// - Counting happens at an edge only when both active-low enables are low, else it holds.
// - Carry goes low while both enables are low and the count is 255 up or zero down.
// - Carry stays high whenever either enable is high, whatever the count.
// - Enables may change at any time; only their values at the rising edge count.
module up_down_counter_8bit
    import up_down_counter_pkg::*;
(
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 mode_sel_low,
    input  wire logic                 mode_sel_high,
    input  wire logic                 count_en_parallel_n,
    input  wire logic                 count_en_trickle_n,
    input  wire logic [`CNT_W-1:0]    data_in,
    output logic      [`CNT_W-1:0]    count_out,
    output logic                      carry_out_n,
    input  wire logic [31:0]          awaddr,
    input  wire logic [2:0]           awprot,
    input  wire logic                 awvalid,
    output logic                      awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output logic                      wready,
    output logic      [1:0]           bresp,
    output logic                      bvalid,
    input  wire logic                 bready,
    input  wire logic [31:0]          araddr,
    input  wire logic [2:0]           arprot,
    input  wire logic                 arvalid,
    output logic                      arready,
    output logic      [31:0]          rdata,
    output logic      [1:0]           rresp,
    output logic                      rvalid,
    input  wire logic                 rready
);

    // Pin synchronisation
    logic [`SYNC_W-1:0] pins_raw;
    logic [`SYNC_W-1:0] pins;

    assign pins_raw = {count_en_trickle_n, count_en_parallel_n,
                       mode_sel_high, mode_sel_low, data_in};

    pin_sync u_pin_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .pin_in  (pins_raw),
        .pin_out (pins)
    );

    // Register file state
    logic [`CTRL_W-1:0] ctrl;
    logic [`CNT_W-1:0]  sw_data;
    logic [`CTRL_W-1:0] next_ctrl;
    logic [`CNT_W-1:0]  next_sw_data;

    // Write channel state
    logic               aw_held;
    logic [31:0]        aw_addr_q;
    logic               w_held;
    logic [31:0]        w_data_q;
    logic [3:0]         w_strb_q;
    logic               bvalid_q;
    logic [1:0]         bresp_q;
    logic               next_aw_held;
    logic [31:0]        next_aw_addr_q;
    logic               next_w_held;
    logic [31:0]        next_w_data_q;
    logic [3:0]         next_w_strb_q;
    logic               next_bvalid_q;
    logic [1:0]         next_bresp_q;

    // Read channel state
    logic               rvalid_q;
    logic [31:0]        rdata_q;
    logic [1:0]         rresp_q;
    logic               next_rvalid_q;
    logic [31:0]        next_rdata_q;
    logic [1:0]         next_rresp_q;

    // Counter state
    count_t             count_q;
    count_t             next_count_q;

    // Effective controls: pins, or the control register when software drives
    mode_e              mode;
    logic               enp_n;
    logic               ent_n;
    count_t             load_val;
    logic               count_ok;
    logic               at_terminal;

    always_comb begin
        if (ctrl[`CTRL_SW_BIT]) begin
            mode     = mode_e'({ctrl[`CTRL_SEL_HIGH], ctrl[`CTRL_SEL_LOW]});
            enp_n    = ctrl[`CTRL_ENP_BIT];
            ent_n    = ctrl[`CTRL_ENT_BIT];
            load_val = sw_data;
        end else begin
            mode     = mode_e'({pins[`SYNC_SEL_HIGH], pins[`SYNC_SEL_LOW]});
            enp_n    = pins[`SYNC_ENP];
            ent_n    = pins[`SYNC_ENT];
            load_val = pins[`SYNC_DATA_MSB:`SYNC_DATA_LSB];
        end
    end

    // Enables are sampled at the edge only
    assign count_ok = !enp_n && !ent_n;

    // Counter next value
    always_comb begin
        next_count_q = count_q;
        case (mode)
            MODE_CLEAR: begin
                next_count_q = `CNT_ZERO;
            end
            MODE_DOWN: begin
                if (count_ok) begin
                    next_count_q = count_t'(count_q - `CNT_ONE);
                end
            end
            MODE_LOAD: begin
                next_count_q = load_val;
            end
            MODE_UP: begin
                if (count_ok) begin
                    next_count_q = count_t'(count_q + `CNT_ONE);
                end
            end
            default: begin
                next_count_q = count_q;
            end
        endcase
        if (!aresetn) begin
            next_count_q = `CNT_ZERO;
        end
    end

    always_ff @(posedge aclk) begin
        count_q <= next_count_q;
    end

    // Clear overrides the stored count without waiting for an edge
    assign count_out = (mode == MODE_CLEAR) ? `CNT_ZERO : count_q;

    always_comb begin
        at_terminal = 1'b0;
        if (mode == MODE_UP) begin
            at_terminal = (count_out == `CNT_MAX);
        end else if (mode == MODE_DOWN) begin
            at_terminal = (count_out == `CNT_ZERO);
        end
    end

    // Carry needs the parallel enable too, so either enable high keeps it high
    assign carry_out_n = !(at_terminal && !ent_n && !enp_n);

    // AXI4-Lite write path: address and data taken in either order
    logic               aw_take;
    logic               w_take;
    logic               have_aw;
    logic               have_w;
    logic [31:0]        wr_addr;
    logic [31:0]        wr_data;
    logic [3:0]         wr_strb;

    assign awready = !aw_held && !bvalid_q;
    assign wready  = !w_held && !bvalid_q;
    assign aw_take = awvalid && awready;
    assign w_take  = wvalid && wready;
    assign have_aw = aw_held || aw_take;
    assign have_w  = w_held || w_take;
    assign wr_addr = (aw_held ? aw_addr_q : awaddr) & `ADDR_WORD_MASK;
    assign wr_data = w_held ? w_data_q : wdata;
    assign wr_strb = w_held ? w_strb_q : wstrb;

    always_comb begin
        next_aw_held   = aw_held;
        next_aw_addr_q = aw_addr_q;
        next_w_held    = w_held;
        next_w_data_q  = w_data_q;
        next_w_strb_q  = w_strb_q;
        next_bvalid_q  = bvalid_q;
        next_bresp_q   = bresp_q;
        next_ctrl      = ctrl;
        next_sw_data   = sw_data;
        if (aw_take) begin
            next_aw_held   = 1'b1;
            next_aw_addr_q = awaddr;
        end
        if (w_take) begin
            next_w_held   = 1'b1;
            next_w_data_q = wdata;
            next_w_strb_q = wstrb;
        end
        if (bvalid_q && bready) begin
            next_bvalid_q = 1'b0;
        end
        if (have_aw && have_w && !bvalid_q) begin
            next_aw_held  = 1'b0;
            next_w_held   = 1'b0;
            next_bvalid_q = 1'b1;
            next_bresp_q  = `RESP_OKAY;
            if (wr_addr == `ADDR_CTRL) begin
                if (wr_strb[0]) begin
                    next_ctrl = wr_data[`CTRL_W-1:0];
                end
            end else if (wr_addr == `ADDR_DATA) begin
                if (wr_strb[0]) begin
                    next_sw_data = wr_data[`CNT_W-1:0];
                end
            end else if (wr_addr == `ADDR_STATUS) begin
                next_bresp_q = `RESP_OKAY;
            end else begin
                next_bresp_q = `RESP_SLVERR;
            end
        end
        if (!aresetn) begin
            next_aw_held   = 1'b0;
            next_aw_addr_q = `WORD_ZERO;
            next_w_held    = 1'b0;
            next_w_data_q  = `WORD_ZERO;
            next_w_strb_q  = 4'h0;
            next_bvalid_q  = 1'b0;
            next_bresp_q   = `RESP_OKAY;
            next_ctrl      = `CTRL_RESET;
            next_sw_data   = `CNT_ZERO;
        end
    end

    always_ff @(posedge aclk) begin
        aw_held   <= next_aw_held;
        aw_addr_q <= next_aw_addr_q;
        w_held    <= next_w_held;
        w_data_q  <= next_w_data_q;
        w_strb_q  <= next_w_strb_q;
        bvalid_q  <= next_bvalid_q;
        bresp_q   <= next_bresp_q;
        ctrl      <= next_ctrl;
        sw_data   <= next_sw_data;
    end

    assign bvalid = bvalid_q;
    assign bresp  = bresp_q;

    // AXI4-Lite read path
    logic [31:0]        rd_addr;
    logic [31:0]        status_word;

    assign arready = !rvalid_q;
    assign rd_addr = araddr & `ADDR_WORD_MASK;

    always_comb begin
        status_word = `WORD_ZERO;
        status_word[`STAT_CNT_LSB +: `CNT_W] = count_out;
        status_word[`STAT_CARRY_BIT]         = carry_out_n;
        status_word[`STAT_MODE_LSB +: 2]     = mode;
    end

    always_comb begin
        next_rvalid_q = rvalid_q;
        next_rdata_q  = rdata_q;
        next_rresp_q  = rresp_q;
        if (rvalid_q && rready) begin
            next_rvalid_q = 1'b0;
        end
        if (arvalid && arready) begin
            next_rvalid_q = 1'b1;
            next_rresp_q  = `RESP_OKAY;
            next_rdata_q  = `WORD_ZERO;
            if (rd_addr == `ADDR_CTRL) begin
                next_rdata_q[`CTRL_W-1:0] = ctrl;
            end else if (rd_addr == `ADDR_DATA) begin
                next_rdata_q[`CNT_W-1:0] = sw_data;
            end else if (rd_addr == `ADDR_STATUS) begin
                next_rdata_q = status_word;
            end else begin
                next_rresp_q = `RESP_SLVERR;
            end
        end
        if (!aresetn) begin
            next_rvalid_q = 1'b0;
            next_rdata_q  = `WORD_ZERO;
            next_rresp_q  = `RESP_OKAY;
        end
    end

    always_ff @(posedge aclk) begin
        rvalid_q <= next_rvalid_q;
        rdata_q  <= next_rdata_q;
        rresp_q  <= next_rresp_q;
    end

    assign rvalid = rvalid_q;
    assign rdata  = rdata_q;
    assign rresp  = rresp_q;

endmodule

//--- src/up_down_counter_consts.svh
`ifndef UP_DOWN_COUNTER_CONSTS_SVH
`define UP_DOWN_COUNTER_CONSTS_SVH

// Counter geometry
`define CNT_W           8
`define CNT_ZERO        8'h00
`define CNT_ONE         8'h01
`define CNT_MAX         8'hff

// Synchronised pin bundle: {ent_n, enp_n, sel_high, sel_low, data[7:0]}
`define SYNC_W          12
`define SYNC_DATA_LSB   0
`define SYNC_DATA_MSB   7
`define SYNC_SEL_LOW    8
`define SYNC_SEL_HIGH   9
`define SYNC_ENP        10
`define SYNC_ENT        11
`define SYNC_RESET      12'hc00

// Register byte addresses
`define ADDR_CTRL       32'h0000_0000
`define ADDR_DATA       32'h0000_0004
`define ADDR_STATUS     32'h0000_0008
`define ADDR_WORD_MASK  32'hffff_fffc

// Control register fields
`define CTRL_SW_BIT     0
`define CTRL_SEL_LOW    1
`define CTRL_SEL_HIGH   2
`define CTRL_ENP_BIT    3
`define CTRL_ENT_BIT    4
`define CTRL_W          5
`define CTRL_RESET      5'h18

// Status register fields
`define STAT_CNT_LSB    0
`define STAT_CARRY_BIT  8
`define STAT_MODE_LSB   9

// Bus constants
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
`define WORD_ZERO       32'h0000_0000

`endif

//--- src/up_down_counter_pkg.sv
package up_down_counter_pkg;

    // Encoded as {mode_sel_high, mode_sel_low}
    typedef enum logic [1:0] {
        MODE_CLEAR = 2'b00,
        MODE_DOWN  = 2'b01,
        MODE_LOAD  = 2'b10,
        MODE_UP    = 2'b11
    } mode_e;

    typedef logic [7:0] count_t;

endpackage

//--- tb/ctl_logic.sv
`timescale 1ns/1ps
module ctl_logic
    import up_down_counter_pkg::*;
(
    input  wire logic   aclk,
    input  wire logic   aresetn,
    input  wire mode_e  cmd_mode,
    input  wire logic   cmd_enp_n,
    input  wire logic   cmd_ent_n,
    input  wire count_t cmd_data,
    input  wire logic   carry_in_n,
    output logic        mode_sel_low,
    output logic        mode_sel_high,
    output logic        count_en_parallel_n,
    output logic        count_en_trickle_n,
    output count_t      data_in,
    output count_t      upper_count
);
    // Next stage of a wider counter: its enables are this stage's carry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            upper_count <= 8'h00;
        end else if (!carry_in_n) begin
            upper_count <= upper_count + 8'h01;
        end
    end
    // One register drives both selects, so they always switch on the same edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {mode_sel_high, mode_sel_low} <= MODE_CLEAR;
            {count_en_parallel_n, count_en_trickle_n} <= 2'b11;
            data_in <= 8'h00;
        end else begin
            {mode_sel_high, mode_sel_low} <= cmd_mode;
            {count_en_parallel_n, count_en_trickle_n} <= {cmd_enp_n, cmd_ent_n};
            data_in <= cmd_data;
        end
    end
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
`include "up_down_counter_consts.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module testbench
    import up_down_counter_pkg::*;
;
    logic        aclk = 1'b0, aresetn = 1'b0;
    mode_e       cmd_mode = MODE_CLEAR;
    logic        cmd_enp_n = 1'b1, cmd_ent_n = 1'b1;
    count_t      cmd_data = 8'h00;
    logic        mode_sel_low, mode_sel_high, count_en_parallel_n, count_en_trickle_n;
    count_t      data_in, count_out, upper_count;
    logic        carry_out_n;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rd;
    logic [3:0]  wstrb = 4'h0;
    logic [2:0]  prot = 3'h0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rs;
    int          n_mismatch = 0, check_count = 0, lo_cnt = 0;

    ctl_logic ctl (.aclk, .aresetn, .cmd_mode, .cmd_enp_n, .cmd_ent_n, .cmd_data,
        .carry_in_n(carry_out_n), .mode_sel_low, .mode_sel_high, .count_en_parallel_n,
        .count_en_trickle_n, .data_in, .upper_count);
    up_down_counter_8bit uut (.aclk, .aresetn, .mode_sel_low, .mode_sel_high,
        .count_en_parallel_n, .count_en_trickle_n, .data_in, .count_out, .carry_out_n,
        .awaddr, .awprot(prot), .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
        .bvalid, .bready, .araddr, .arprot(prot), .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready);

    always #12.5 aclk = ~aclk;
    // Counts cycles with the carry asserted
    always @(negedge aclk) if (carry_out_n === 1'b0) lo_cnt++;

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic cmd(input mode_e m, input logic p, input logic t, input count_t d);
        @(posedge aclk);
        cmd_mode <= m;
        cmd_enp_n <= p;
        cmd_ent_n <= t;
        cmd_data <= d;
    endtask

    // Both enables low for n edges, then trickle stays low alone
    task automatic run(input mode_e m, input int n);
        repeat (n) cmd(m, 1'b0, 1'b0, cmd_data);
        cmd(m, 1'b1, 1'b0, cmd_data);
        repeat (5) @(posedge aclk);
    endtask

    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        {awvalid, wvalid, bready} <= 3'b111;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                done = 1'b1;
                `CHK(bresp, er);
            end
        end
        if (!done) begin
            n_mismatch++;
            end_of_test();
        end
    endtask

    task automatic axi_rd(input logic [31:0] a);
        logic done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                done = 1'b1;
                rd = rdata;
                rs = rresp;
            end
        end
        if (!done) begin
            n_mismatch++;
            end_of_test();
        end
    endtask

    task automatic t_reset();
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        `CHK(count_out, 8'h00);
        `CHK(carry_out_n, 1'b1);
        $display("reset done");
    endtask

    task automatic t_steps();
        cmd(MODE_LOAD, 1'b1, 1'b1, 8'h10);
        repeat (4) @(posedge aclk);
        cmd(MODE_UP, 1'b1, 1'b1, 8'h10);
        repeat (4) @(posedge aclk);
        run(MODE_UP, 6);
        `CHK(count_out, 8'h16);
        run(MODE_DOWN, 9);
        `CHK(count_out, 8'h0d);
        $display("steps done");
    endtask

    task automatic t_load();
        cmd(MODE_LOAD, 1'b1, 1'b1, 8'h1e);
        repeat (5) @(posedge aclk);
        `CHK(count_out, 8'h1e);
        $display("load done");
    endtask

    task automatic t_up();
        cmd(MODE_LOAD, 1'b1, 1'b1, 8'hfe);
        cmd(MODE_UP, 1'b1, 1'b1, 8'hfe);
        repeat (5) @(posedge aclk);
        `CHK(count_out, 8'hfe);
        run(MODE_UP, 1);
        `CHK(count_out, 8'hff);
        `CHK(carry_out_n, 1'b1);
        lo_cnt = 0;
        run(MODE_UP, 1);
        `CHK(count_out, 8'h00);
        `CHK(lo_cnt, 1);
        `CHK(upper_count, 8'h01);
        $display("up done");
    endtask

    task automatic t_down();
        cmd(MODE_LOAD, 1'b1, 1'b1, 8'h01);
        repeat (4) @(posedge aclk);
        cmd(MODE_DOWN, 1'b1, 1'b1, 8'h01);
        repeat (5) @(posedge aclk);
        lo_cnt = 0;
        run(MODE_DOWN, 2);
        `CHK(count_out, 8'hff);
        `CHK(lo_cnt, 1);
        `CHK(upper_count, 8'h01);
        cmd(MODE_CLEAR, 1'b1, 1'b1, 8'h00);
        repeat (4) @(posedge aclk);
        `CHK(count_out, 8'h00);
        $display("down and clear done");
    endtask

    task automatic t_regs();
        axi_rd(`ADDR_CTRL);
        `CHK(rd, 32'h0000_0018);
        axi_wr(`ADDR_DATA, 32'h0000_003c, `RESP_OKAY);
        axi_wr(`ADDR_CTRL, 32'h0000_001d, `RESP_OKAY);
        repeat (3) @(posedge aclk);
        axi_rd(`ADDR_STATUS);
        `CHK(rd, 32'h0000_053c);
        axi_rd(32'h0000_0010);
        `CHK(rs, `RESP_SLVERR);
        axi_wr(32'h0000_0010, 32'h0000_0001, `RESP_SLVERR);
        axi_wr(`ADDR_CTRL, 32'h0000_0018, `RESP_OKAY);
        repeat (4) @(posedge aclk);
        `CHK(count_out, 8'h00);
        $display("registers done");
    endtask

    initial begin
        t_reset();
        t_load();
        t_up();
        t_steps();
        t_reset();
        t_down();
        t_regs();
        end_of_test();
    end
endmodule

//--- tb/up_down_counter_props.sv
`timescale 1ns/1ps
`include "up_down_counter_consts.svh"
module up_down_counter_props
    import up_down_counter_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        mode_sel_low,
    input wire logic        mode_sel_high,
    input wire logic        count_en_parallel_n,
    input wire logic        count_en_trickle_n,
    input wire logic [7:0]  data_in,
    input wire logic [7:0]  count_out,
    input wire logic        carry_out_n,
    input wire logic [31:0] awaddr,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic [31:0] wdata
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Pin history mirrors the two-flop synchroniser inside the block
    logic [11:0] h1, h2, h3, h4;
    logic        sw;
    logic [3:0]  sw_h;
    wire  [11:0] pins = {count_en_trickle_n, count_en_parallel_n, mode_sel_high, mode_sel_low,
                         data_in};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            {h1, h2, h3, h4} <= {4{`SYNC_RESET}};
            sw <= 1'b0;
            sw_h <= 4'h0;
        end else begin
            {h1, h2, h3, h4} <= {pins, h1, h2, h3};
            sw_h <= {sw_h[2:0], sw};
            if (awvalid && awready && (awaddr & `ADDR_WORD_MASK) == `ADDR_CTRL) begin
                sw <= wdata[0];
            end
        end
    end
    // Pins are ignored while software drives the controls, and a while after
    wire       ok = !sw && sw_h == 4'h0;
    wire       stdy = ok && h2 == h3 && h3 == h4;
    wire [1:0] m2 = h2[9:8];
    wire [1:0] m3 = h3[9:8];
    wire       en2 = h2[11:10] == 2'b00;
    wire       en3 = h3[11:10] == 2'b00;

    load_data_a: assert property (stdy && m3 == MODE_LOAD |-> count_out == h3[7:0])
        else $error("load value not on count");
    clear_zero_a: assert property (ok && m2 == MODE_CLEAR |-> count_out == `CNT_ZERO)
        else $error("clear did not force zero");
    count_up_a: assert property (
        stdy && m3 == MODE_UP && en3 |-> count_out == $past(count_out) + `CNT_ONE)
        else $error("up count step wrong");
    count_down_a: assert property (
        stdy && m3 == MODE_DOWN && en3 |-> count_out == $past(count_out) - `CNT_ONE)
        else $error("down count step wrong");
    hold_count_a: assert property (stdy && m3[0] && !en3 |-> $stable(count_out))
        else $error("count moved while disabled");
    carry_idle_a: assert property (ok && h2[11:10] != 2'b00 |-> carry_out_n)
        else $error("carry low with an enable high");
    carry_term_a: assert property (
        ok && en2 && ((m2 == MODE_UP && count_out == `CNT_MAX) ||
                      (m2 == MODE_DOWN && count_out == `CNT_ZERO)) |-> !carry_out_n)
        else $error("carry missing at terminal count");
    carry_mode_a: assert property (ok && !m2[0] |-> carry_out_n)
        else $error("carry low outside counting");
endmodule
bind up_down_counter_8bit up_down_counter_props chk (.aclk, .aresetn, .mode_sel_low,
    .mode_sel_high, .count_en_parallel_n, .count_en_trickle_n, .data_in, .count_out,
    .carry_out_n, .awaddr, .awvalid, .awready, .wdata);
